// >>> verilog/lcdd_defines.svh
// Register indices, field positions, reset values and scan timing counts
`ifndef LCDD_DEFINES_SVH
`define LCDD_DEFINES_SVH

`define LCDD_IDX_DDC 10'h093
`define LCDD_IDX_P0E 10'h09c
`define LCDD_IDX_AUX 10'h098
`define LCDD_IDX_STAT 10'h099

`define LCDD_DDC_RST 8'h00
`define LCDD_P0E_RST 8'h00
`define LCDD_AUX_RST 5'h00

`define LCDD_DDC_SCAN_BIT 7
`define LCDD_DDC_KIND_BIT 6
`define LCDD_DDC_DUTY_HI 5
`define LCDD_DDC_DUTY_LO 4
`define LCDD_DDC_TRIM_HI 3
`define LCDD_DDC_TRIM_LO 0
`define LCDD_AUX_BIAS_BIT 0
`define LCDD_AUX_SWAP_BIT 1
`define LCDD_AUX_DRV_HI 3
`define LCDD_AUX_DRV_LO 2
`define LCDD_AUX_CLKSRC_BIT 4

`define LCDD_VLCD_BASE 5'h11
`define LCDD_OSC_HZ 32768
`define LCDD_FRAME_HZ 64
`define LCDD_FRAME_TICKS (`LCDD_OSC_HZ / `LCDD_FRAME_HZ)
`define LCDD_SLOT_8 9'(`LCDD_FRAME_TICKS / 8)
`define LCDD_SLOT_6 9'(`LCDD_FRAME_TICKS / 6)
`define LCDD_SLOT_5 9'(`LCDD_FRAME_TICKS / 5)
`define LCDD_SLOT_4 9'(`LCDD_FRAME_TICKS / 4)

`define LCDD_SEG_8 28'hffffff0
`define LCDD_SEG_6 28'hffffffc
`define LCDD_SEG_5 28'hffffffe
`define LCDD_SEG_4A 28'hfffffff
`define LCDD_SEG_4B 28'hffffff0

`define LCDD_RESP_OKAY 2'h0
`define LCDD_RESP_SLVERR 2'h2

`endif

// >>> verilog/lcdd_pkg.sv
// Types shared by the display scan driver modules
package lcdd_pkg;
    typedef enum logic [1:0] {
        LCDD_DUTY_8 = 2'b00,
        LCDD_DUTY_6 = 2'b01,
        LCDD_DUTY_5 = 2'b10,
        LCDD_DUTY_4 = 2'b11
    } lcdd_duty_t;

    typedef enum logic [2:0] {
        LCDD_SEL_NONE = 3'b000,
        LCDD_SEL_DDC = 3'b001,
        LCDD_SEL_P0E = 3'b010,
        LCDD_SEL_AUX = 3'b011,
        LCDD_SEL_STAT = 3'b100
    } lcdd_sel_t;

    typedef struct packed {
        logic scan_active;
        logic led_mode;
        logic bias_third;
        logic [4:0] vlcd_num;
        logic [1:0] com_drive_level;
        logic [1:0] seg_drive_level;
        logic frame_invert;
        logic [7:0] com_enable;
        logic [7:0] com_level;
        logic [27:0] seg_enable;
        logic [27:0] seg_level;
    } lcdd_drive_t;

    typedef struct packed {
        logic [2:0] lrc_sync;
        logic [2:0] ext_sync;
        logic lrc_filt;
        logic ext_filt;
        logic tick;
    } lcdd_clk_state_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_held;
        logic w_held;
        logic [11:0] aw_addr;
        logic [7:0] w_data;
        logic w_strb0;
        logic [7:0] ddc;
        logic [7:0] p0e;
        logic [4:0] aux;
        logic [8:0] slot_cnt;
        logic [2:0] com_idx;
        logic invert;
        lcdd_drive_t drive;
    } lcdd_state_t;
endpackage

// >>> verilog/lcdd_scan_clock.sv
// Scan time base: synchronises the slow oscillators and emits one tick per rising edge of the selected one
`timescale 1ns/10ps
`include "lcdd_defines.svh"
module lcdd_scan_clock (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Source select and oscillator inputs
    input wire logic src_ext,
    input wire logic lrc_osc,
    input wire logic ext_osc,
    // Tick out
    output logic tick
);
    lcdd_pkg::lcdd_clk_state_t s_reg;
    lcdd_pkg::lcdd_clk_state_t s_next;
    logic lrc_rise;
    logic ext_rise;

    always_comb begin
        s_next = s_reg;
        s_next.lrc_sync = {s_reg.lrc_sync[1:0], lrc_osc};
        s_next.ext_sync = {s_reg.ext_sync[1:0], ext_osc};
        // Level counts only once the second and third stages agree
        if (s_reg.lrc_sync[1] == s_reg.lrc_sync[2]) begin
            s_next.lrc_filt = s_reg.lrc_sync[2];
        end
        if (s_reg.ext_sync[1] == s_reg.ext_sync[2]) begin
            s_next.ext_filt = s_reg.ext_sync[2];
        end
        lrc_rise = (s_reg.lrc_sync[1] == s_reg.lrc_sync[2]) && s_reg.lrc_sync[2] && !s_reg.lrc_filt;
        ext_rise = (s_reg.ext_sync[1] == s_reg.ext_sync[2]) && s_reg.ext_sync[2] && !s_reg.ext_filt;
        s_next.tick = src_ext ? ext_rise : lrc_rise;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    tick_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.tick |-> ($past(src_ext) ? $rose(s_reg.ext_filt) : $rose(s_reg.lrc_filt)))
        else $error("scan tick without an oscillator rising edge");

    tick_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_reg.tick |=> !s_reg.tick ##1 !s_reg.tick)
        else $error("scan tick repeated too soon");
endmodule

// >>> verilog/lcdd_scan_driver.sv
// Multiplexed LCD/LED scan driver with its AXI4-Lite register slave
`timescale 1ns/10ps
`include "lcdd_defines.svh"
module lcdd_scan_driver (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Scan oscillators
    input wire logic lrc_osc,
    input wire logic ext_osc,
    // Pattern fetch for the current common
    output logic [2:0] scan_com_index,
    input wire logic [27:0] seg_pattern,
    // Display drive
    output lcdd_pkg::lcdd_drive_t drive
);
    lcdd_pkg::lcdd_state_t s_reg;
    lcdd_pkg::lcdd_state_t s_next;
    logic tick;
    logic scan_on;
    logic led;
    logic lcd_inv;
    logic swap;
    lcdd_pkg::lcdd_duty_t duty;
    logic [2:0] first;
    logic [2:0] last;
    logic [8:0] slot_len;
    logic [27:0] seg_mask;
    logic [7:0] com_mask;
    logic [1:0] drv;
    lcdd_pkg::lcdd_sel_t wsel;
    lcdd_pkg::lcdd_sel_t rsel;

    function automatic lcdd_pkg::lcdd_sel_t decode(input logic [11:0] addr);
        if (addr[1:0] != 2'h0) begin
            return lcdd_pkg::LCDD_SEL_NONE;
        end
        unique case (addr[11:2])
            `LCDD_IDX_DDC: return lcdd_pkg::LCDD_SEL_DDC;
            `LCDD_IDX_P0E: return lcdd_pkg::LCDD_SEL_P0E;
            `LCDD_IDX_AUX: return lcdd_pkg::LCDD_SEL_AUX;
            `LCDD_IDX_STAT: return lcdd_pkg::LCDD_SEL_STAT;
            default: return lcdd_pkg::LCDD_SEL_NONE;
        endcase
    endfunction

    function automatic logic [2:0] com_first(input lcdd_pkg::lcdd_duty_t d, input logic sw);
        unique case (d)
            lcdd_pkg::LCDD_DUTY_8: return 3'h0;
            lcdd_pkg::LCDD_DUTY_6: return 3'h2;
            lcdd_pkg::LCDD_DUTY_5: return 3'h3;
            lcdd_pkg::LCDD_DUTY_4: return sw ? 3'h0 : 3'h4;
        endcase
    endfunction

    function automatic logic [2:0] com_last(input lcdd_pkg::lcdd_duty_t d, input logic sw);
        return (d == lcdd_pkg::LCDD_DUTY_4 && sw) ? 3'h3 : 3'h7;
    endfunction

    function automatic logic [8:0] slot_ticks(input lcdd_pkg::lcdd_duty_t d);
        unique case (d)
            lcdd_pkg::LCDD_DUTY_8: return `LCDD_SLOT_8;
            lcdd_pkg::LCDD_DUTY_6: return `LCDD_SLOT_6;
            lcdd_pkg::LCDD_DUTY_5: return `LCDD_SLOT_5;
            lcdd_pkg::LCDD_DUTY_4: return `LCDD_SLOT_4;
        endcase
    endfunction

    function automatic logic [27:0] seg_lines(input lcdd_pkg::lcdd_duty_t d, input logic sw);
        unique case (d)
            lcdd_pkg::LCDD_DUTY_8: return `LCDD_SEG_8;
            lcdd_pkg::LCDD_DUTY_6: return `LCDD_SEG_6;
            lcdd_pkg::LCDD_DUTY_5: return `LCDD_SEG_5;
            lcdd_pkg::LCDD_DUTY_4: return sw ? `LCDD_SEG_4B : `LCDD_SEG_4A;
        endcase
    endfunction

    function automatic logic [7:0] com_lines(input logic [2:0] lo, input logic [2:0] hi);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (3'(i) >= lo) && (3'(i) <= hi);
        end
        return m;
    endfunction

    function automatic logic [7:0] read_value(input lcdd_pkg::lcdd_sel_t sel, input lcdd_pkg::lcdd_state_t st);
        unique case (sel)
            lcdd_pkg::LCDD_SEL_DDC: return st.ddc;
            lcdd_pkg::LCDD_SEL_P0E: return st.p0e;
            lcdd_pkg::LCDD_SEL_AUX: return {3'h0, st.aux};
            lcdd_pkg::LCDD_SEL_STAT: return {3'h0, st.ddc[`LCDD_DDC_SCAN_BIT], st.invert, st.com_idx};
            default: return 8'h00;
        endcase
    endfunction

    lcdd_scan_clock u_clock (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_ext(s_reg.aux[`LCDD_AUX_CLKSRC_BIT]),
        .lrc_osc(lrc_osc),
        .ext_osc(ext_osc),
        .tick(tick)
    );

    always_comb begin
        s_next = s_reg;
        scan_on = s_reg.ddc[`LCDD_DDC_SCAN_BIT];
        led = s_reg.ddc[`LCDD_DDC_KIND_BIT];
        // Polarity masked at once on a switch to LED, not one cycle later
        lcd_inv = s_reg.invert && !led;
        duty = lcdd_pkg::lcdd_duty_t'(s_reg.ddc[`LCDD_DDC_DUTY_HI:`LCDD_DDC_DUTY_LO]);
        swap = s_reg.aux[`LCDD_AUX_SWAP_BIT];
        drv = s_reg.aux[`LCDD_AUX_DRV_HI:`LCDD_AUX_DRV_LO];
        first = com_first(duty, swap);
        last = com_last(duty, swap);
        slot_len = slot_ticks(duty);
        seg_mask = seg_lines(duty, swap);
        com_mask = com_lines(first, last);
        wsel = decode(s_reg.aw_addr);
        rsel = decode(araddr);

        // Write address and data, taken in either order
        if (awvalid && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = wdata[7:0];
            s_next.w_strb0 = wstrb[0];
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = (wsel == lcdd_pkg::LCDD_SEL_NONE) ? `LCDD_RESP_SLVERR : `LCDD_RESP_OKAY;
            if (s_reg.w_strb0) begin
                unique case (wsel)
                    lcdd_pkg::LCDD_SEL_DDC: s_next.ddc = s_reg.w_data;
                    lcdd_pkg::LCDD_SEL_P0E: s_next.p0e = s_reg.w_data;
                    lcdd_pkg::LCDD_SEL_AUX: s_next.aux = s_reg.w_data[4:0];
                    default: s_next.ddc = s_reg.ddc;
                endcase
            end
        end
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;

        // Read
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = {24'h000000, read_value(rsel, s_reg)};
            s_next.rresp = (rsel == lcdd_pkg::LCDD_SEL_NONE) ? `LCDD_RESP_SLVERR : `LCDD_RESP_OKAY;
        end
        s_next.arready = !s_next.rvalid;

        // Common slot sequencer
        if (!scan_on) begin
            s_next.slot_cnt = 9'h000;
        end else if (s_reg.com_idx < first || s_reg.com_idx > last) begin
            s_next.com_idx = first;
            s_next.slot_cnt = 9'h000;
        end else if (tick) begin
            if (s_reg.slot_cnt >= slot_len - 9'h001) begin
                s_next.slot_cnt = 9'h000;
                if (s_reg.com_idx == last) begin
                    s_next.com_idx = first;
                    s_next.invert = !s_reg.invert;
                end else begin
                    s_next.com_idx = s_reg.com_idx + 3'h1;
                end
            end else begin
                s_next.slot_cnt = s_reg.slot_cnt + 9'h001;
            end
        end
        // LED drive is never frame-inverted
        if (led) begin
            s_next.invert = 1'b0;
        end

        // Registered drive outputs
        s_next.drive.scan_active = scan_on;
        s_next.drive.led_mode = led;
        s_next.drive.bias_third = !led && s_reg.aux[`LCDD_AUX_BIAS_BIT];
        s_next.drive.vlcd_num = `LCDD_VLCD_BASE + {1'b0, s_reg.ddc[`LCDD_DDC_TRIM_HI:`LCDD_DDC_TRIM_LO]};
        s_next.drive.com_drive_level = led ? 2'h0 : drv;
        s_next.drive.seg_drive_level = led ? drv : 2'h0;
        s_next.drive.frame_invert = lcd_inv;
        s_next.drive.com_enable = scan_on ? (com_mask & s_reg.p0e) : 8'h00;
        s_next.drive.com_level = s_next.drive.com_enable & ((8'h01 << s_reg.com_idx) ^ {8{lcd_inv}});
        s_next.drive.seg_enable = scan_on ? seg_mask : 28'h0000000;
        s_next.drive.seg_level = s_next.drive.seg_enable & (seg_pattern ^ {28{lcd_inv}});
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.ddc <= `LCDD_DDC_RST;
            s_reg.p0e <= `LCDD_P0E_RST;
            s_reg.aux <= `LCDD_AUX_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    assign scan_com_index = s_reg.com_idx;
    assign drive = s_reg.drive;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence slot_end_s;
        scan_on && tick && s_reg.com_idx >= first && s_reg.com_idx <= last && s_reg.slot_cnt >= slot_len - 9'h001;
    endsequence

    sequence mid_frame_s;
        slot_end_s ##0 (s_reg.com_idx != last);
    endsequence

    sequence frame_end_s;
        slot_end_s ##0 (s_reg.com_idx == last);
    endsequence

    reset_values_a: assert property (disable iff (1'b0)
        !aresetn |=> (s_reg.ddc == 8'h00 && s_reg.p0e == 8'h00 && drive.com_enable == 8'h00))
        else $error("control registers not cleared by reset");

    scan_off_quiet_a: assert property (
        !scan_on |=> (drive.com_enable == 8'h00 && drive.seg_enable == 28'h0000000 && !drive.scan_active))
        else $error("display driven while scan is off");

    scan_hold_a: assert property (
        (!scan_on ##1 !scan_on) |-> $stable(s_reg.com_idx) && s_reg.slot_cnt == 9'h000)
        else $error("common advanced while scan is off");

    cyclic_step_a: assert property (
        mid_frame_s |=> s_reg.com_idx == $past(s_reg.com_idx) + 3'h1)
        else $error("common did not step to the next line");

    frame_wrap_a: assert property (
        frame_end_s |=> s_reg.com_idx == $past(first) && s_reg.slot_cnt == 9'h000)
        else $error("common did not wrap to the first line");

    one_common_a: assert property (
        drive.led_mode |-> $onehot0(drive.com_level))
        else $error("more than one common selected");

    led_no_invert_a: assert property (
        drive.led_mode && $past(drive.led_mode) |-> !drive.frame_invert && !drive.bias_third
            && drive.com_drive_level == 2'h0)
        else $error("LED mode carries LCD behaviour");

    seg_roles_a: assert property (
        scan_on |=> drive.seg_enable == $past(seg_mask) && (drive.com_enable & ~$past(com_mask)) == 8'h00)
        else $error("segment or common roles do not match duty");

    port_gate_a: assert property (
        1'b1 |=> (drive.com_enable & ~$past(s_reg.p0e)) == 8'h00)
        else $error("common driven on a disabled port pin");

    vlcd_level_a: assert property (
        1'b1 |=> drive.vlcd_num == `LCDD_VLCD_BASE + {1'b0, $past(s_reg.ddc[3:0])})
        else $error("voltage trim numerator wrong");

    write_answer_a: assert property (
        (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) |=> s_reg.bvalid && !s_reg.awready && !s_reg.wready)
        else $error("write response missing");
endmodule

// >>> verilog/lcdd_unused_none.sv
// Intentionally empty
`timescale 1ns/10ps

// >>> verification/lcdd_panel_model.sv
// Far-side stand-in: scan oscillators and the pattern memory of the panel
`timescale 1ns/10ps
module lcdd_panel_model #(
    parameter int LRC_HALF_NS = 20,
    parameter int EXT_HALF_NS = 16
) (
    // Pattern fetch
    input wire logic [2:0] scan_com_index,
    output logic [27:0] seg_pattern,
    // Oscillators
    output logic lrc_osc,
    output logic ext_osc
);
    // Each nibble carries the common index, so every slot shows a distinct pattern
    assign seg_pattern = {7{1'b0, scan_com_index}};

    initial begin
        lrc_osc = 1'b0;
        ext_osc = 1'b0;
    end

    // Sped up far beyond 32 kHz to keep slots short; edges land on aclk falling edges
    always begin
        #LRC_HALF_NS;
        lrc_osc = ~lrc_osc;
    end

    always begin
        #EXT_HALF_NS;
        ext_osc = ~ext_osc;
    end
endmodule

// >>> verification/lcd_led_segment_scan_driver_bench.sv
// Self-checking bench for the display scan driver
`timescale 1ns/10ps
`include "lcdd_defines.svh"
module lcd_led_segment_scan_driver_bench;
    typedef struct packed {
        logic [7:0] aux;
        logic [7:0] ddc;
        logic [7:0] p0e;
        logic [7:0] com;
        logic [27:0] seg;
        logic [11:0] flags;
    } lcdd_row_t;

    localparam logic [11:0] A_DDC = {`LCDD_IDX_DDC, 2'b00};
    localparam logic [11:0] A_P0E = {`LCDD_IDX_P0E, 2'b00};
    localparam logic [11:0] A_AUX = {`LCDD_IDX_AUX, 2'b00};
    localparam logic [11:0] A_STAT = {`LCDD_IDX_STAT, 2'b00};
    // flags: scan, led, bias, vlcd[4:0], com drive, seg drive
    localparam lcdd_row_t ROWS [8] = '{
        '{8'h01, 8'h80, 8'hff, 8'hff, 28'hffffff0, {3'b101, 5'h11, 4'h0}},
        '{8'h00, 8'h9e, 8'hff, 8'hfc, 28'hffffffc, {3'b100, 5'h1f, 4'h0}},
        '{8'h0c, 8'ha5, 8'hff, 8'hf8, 28'hffffffe, {3'b100, 5'h16, 4'hc}},
        '{8'h00, 8'hb0, 8'hff, 8'hf0, 28'hfffffff, {3'b100, 5'h11, 4'h0}},
        '{8'h02, 8'hb0, 8'hff, 8'h0f, 28'hffffff0, {3'b100, 5'h11, 4'h0}},
        '{8'h09, 8'hc0, 8'hff, 8'hff, 28'hffffff0, {3'b110, 5'h11, 4'h2}},
        '{8'h00, 8'h80, 8'h0f, 8'h0f, 28'hffffff0, {3'b100, 5'h11, 4'h0}},
        '{8'h00, 8'h00, 8'hff, 8'h00, 28'h0000000, {3'b000, 5'h11, 4'h0}}
    };

    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, lrc_osc, ext_osc;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [2:0] scan_com_index, idx0;
    logic [27:0] seg_pattern;
    lcdd_pkg::lcdd_drive_t drive;
    int failures, n_checks, len;

    lcdd_scan_driver u_lcdd_scan_driver (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .lrc_osc(lrc_osc), .ext_osc(ext_osc),
        .scan_com_index(scan_com_index), .seg_pattern(seg_pattern), .drive(drive));

    lcdd_panel_model u_lcdd_panel_model (.scan_com_index(scan_com_index), .seg_pattern(seg_pattern),
        .lrc_osc(lrc_osc), .ext_osc(ext_osc));

    always begin
        #2;
        aclk = ~aclk;
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_up(input int n, input int lim);
        if (n >= lim) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, n, lim);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        // One edge between transfers, so no signal is driven twice in a time step
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
            end
        end while (!bvalid && n < 200);
        give_up(n, 200);
    endtask

    task automatic rd_reg(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end while (!rvalid && n < 200);
        give_up(n, 200);
    endtask

    // Waits for the common index to move, counting the cycles taken
    task automatic slot();
        logic [2:0] i0;
        i0 = scan_com_index;
        len = 0;
        while (scan_com_index === i0 && len < 3000) begin
            @(posedge aclk);
            len++;
        end
        give_up(len, 3000);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        failures = 0;
        n_checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (ROWS[i]) begin
            wr(A_AUX, ROWS[i].aux);
            wr(A_P0E, ROWS[i].p0e);
            wr(A_DDC, ROWS[i].ddc);
            rd_reg(A_DDC);
            chk(rd, {24'h0, ROWS[i].ddc});
            repeat (3) @(posedge aclk);
            chk(32'(drive.com_enable), 32'(ROWS[i].com));
            chk(32'(drive.seg_enable), 32'(ROWS[i].seg));
            chk(32'({drive.scan_active, drive.led_mode, drive.bias_third, drive.vlcd_num, drive.com_drive_level,
                drive.seg_drive_level}), 32'(ROWS[i].flags));
            $display("row %0d done", i);
        end
        wr(12'h000, 8'h5a);
        chk(32'(resp), 32'h2);
        rd_reg(12'h000);
        chk({rd[29:0], resp}, 32'h2);
        $display("unmapped done");
        wr(A_AUX, 8'h00);
        wr(A_DDC, 8'hb0);
        // Common 4 already selected; the first step ends a slot begun mid-tick; time the third change
        slot();
        slot();
        idx0 = scan_com_index;
        slot();
        chk(32'(len), 32'd1280);
        chk(32'(scan_com_index), (idx0 == 3'h7) ? 32'h4 : 32'(idx0 + 3'h1));
        $display("quarter duty slots done");
        wr(A_AUX, 8'h10);
        wr(A_DDC, 8'hc0);
        slot();
        idx0 = scan_com_index;
        repeat (10) @(posedge aclk);
        chk(32'(drive.com_level), 32'(8'h01 << idx0));
        chk(32'(drive.seg_level), 32'(`LCDD_SEG_8 & {7{1'b0, idx0}}));
        chk(32'(drive.frame_invert), 32'h0);
        slot();
        chk(32'(len), 32'd502);
        chk(32'(scan_com_index), 32'(3'(idx0 + 3'h1)));
        $display("external clock done");
        wr(A_DDC, 8'h40);
        repeat (2) @(posedge aclk);
        idx0 = scan_com_index;
        repeat (300) @(posedge aclk);
        chk(32'(scan_com_index), 32'(idx0));
        chk(32'({drive.com_enable, drive.com_level, drive.scan_active}), 32'h0);
        chk(32'(drive.seg_enable | drive.seg_level), 32'h0);
        rd_reg(A_STAT);
        chk(rd, 32'(idx0));
        rd_reg(A_AUX);
        chk(rd, 32'h10);
        $display("scan off done");
        rd_reg(A_P0E);
        chk(rd, 32'hff);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(A_DDC);
        chk(rd, 32'h0);
        rd_reg(A_P0E);
        chk(rd, 32'h0);
        $display("reset done");
        print_verdict();
    end
endmodule
